/* File: common/bps_pkg.sv */
// package for the bus power state and power report block
`default_nettype none
package bps_pkg;
	// apb register byte offsets
	localparam logic [7:0] BPS_OFF_PM_CTRL = 8'h00;
	localparam logic [7:0] BPS_OFF_BRIDGE_EXT = 8'h04;
	localparam logic [7:0] BPS_OFF_BUS_STATUS = 8'h08;
	localparam logic [7:0] BPS_OFF_PWR_TABLE = 8'h40;
	localparam logic [7:0] BPS_OFF_PWR_TABLE_END = 8'h64;
	// pm_control_status field positions
	localparam int BPS_PS_LSB = 0;
	localparam int BPS_SEL_LSB = 9;
	localparam int BPS_SCALE_LSB = 13;
	localparam int BPS_DATA_LSB = 16;
	// bridge extension bits
	localparam int BPS_CHOICE_BIT = 6;
	localparam int BPS_ENABLE_BIT = 7;
	localparam int BPS_PWR_UP_BIT = 8;
	// selector values
	localparam logic [3:0] BPS_SEL_COMMON = 4'h8;
	localparam int BPS_TABLE_DEPTH = 9;
	// reset values and scale codes
	localparam logic [3:0] BPS_SEL_RESET = 4'h0;
	localparam logic [7:0] BPS_DATA_RESET = 8'h00;
	localparam logic [1:0] BPS_SCALE_UNKNOWN = 2'h0;
	localparam logic [1:0] BPS_SCALE_TENTH = 2'h1;
	localparam logic [1:0] BPS_SCALE_HUNDREDTH = 2'h2;
	localparam logic [1:0] BPS_SCALE_THOUSANDTH = 2'h3;
	// timing
	localparam int BPS_CLK_MHZ = 250;
	localparam int BPS_RESET_US = 1000;
	localparam int BPS_RESET_CYCLES = BPS_RESET_US * BPS_CLK_MHZ;
	localparam int BPS_SETTLE_NS = 120;
	localparam int BPS_SETTLE_CYCLES = (BPS_SETTLE_NS * BPS_CLK_MHZ + 999) / 1000;
	localparam int BPS_CLK_DIV = 20;

	typedef enum logic [1:0] {
		BPS_FUNC_FULL_POWER = 2'h0,
		BPS_FUNC_LIGHT_SLEEP = 2'h1,
		BPS_FUNC_DEEP_SLEEP = 2'h2,
		BPS_FUNC_HOT_OFF = 2'h3
	} bps_func_state_t;

	typedef enum logic [1:0] {
		BPS_BUS_FULLY_ON = 2'h0,
		BPS_BUS_POWERED_IDLE = 2'h1,
		BPS_BUS_CLOCK_STOPPED = 2'h2,
		BPS_BUS_UNPOWERED = 2'h3
	} bps_bus_state_t;

	// one reporting table entry: measurement byte and its scale code
	typedef struct packed {
		logic [1:0] scale;
		logic [7:0] value;
	} bps_report_t;

	// secondary bus control outputs
	typedef struct packed {
		logic sec_clk;
		logic sec_power_on;
		logic sec_reset_n;
		logic sec_grant_block;
	} bps_sec_ctrl_t;
endpackage
`default_nettype wire

/* File: logic/bps_report_mem.sv */
// small table memory holding the power report entries
`timescale 1ns/1ps
`default_nettype none
module bps_report_mem #(
	parameter int DEPTH = 9,
	parameter int AW = 4
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire bps_pkg::bps_report_t wr_data,
	// read port
	input wire logic [AW-1:0] rd_addr,
	output bps_pkg::bps_report_t rd_data
);
	import bps_pkg::*;

	bps_report_t mem_reg [DEPTH];

	// no reset on the array so it maps onto plain storage
	always_ff @(posedge clk) begin
		if (wr_en && (32'(wr_addr) < DEPTH)) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (32'(rd_addr) < DEPTH) begin
			rd_data <= mem_reg[rd_addr];
		end else begin
			rd_data <= '0;
		end
	end
endmodule
`default_nettype wire

/* File: logic/bps_power_ctrl.sv */
// bus power state sequencer and power report window with apb access
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - selectors 0-3 report max power drawn from bus supply per function state
// - selectors 4-7 report heat released in chassis per function state
// - scale code 0 unknown, 1 tenths, 2 hundredths, 3 thousandths of watt
// - only function 0 of multi-function device answers selector 8 with common logic
// - selectors 9-15 reserved on function 0 of multi-function device, 8-15 elsewhere
// - each reported value is the state's maximum power
// - report values may be loaded at reset from straps
// - powered idle keeps supply and clock, no transactions
// - clock stopped keeps supply, clock held low
// - idle states keep bus signals at valid levels, parking allowed
// - accesses below a bus not fully on end as master abort
// - leaving fully on waits for bus idle before power or clock change
// - supply return asserts bus reset then brings bus to active idle
// - register controlled unpowered entry is optional, power loss yields it
// - 4-bit selector in control register picks measurement and scale
// - bus state tracks function state per mapping
// - hot off with control enabled: choice set stops clock, clear removes supply
module bps_power_ctrl #(
	parameter bit MULTI_FUNC = 1'b1,
	parameter bit FUNC_ZERO = 1'b1,
	parameter int RESET_CYCLES = bps_pkg::BPS_RESET_CYCLES
) (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// straps
	input wire logic strap_enable,
	input wire logic strap_choice,
	input wire logic strap_load,
	input wire bps_pkg::bps_report_t strap_report,
	// secondary bus side
	input wire logic sec_bus_idle_pin,
	input wire logic downstream_req,
	output logic downstream_grant,
	output logic downstream_master_abort,
	output bps_pkg::bps_sec_ctrl_t sec_ctrl,
	output bps_pkg::bps_bus_state_t bus_state
);
	import bps_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic idle_meta_reg, idle_sync_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_meta_reg <= 1'b0;
			idle_sync_reg <= 1'b0;
		end else begin
			idle_meta_reg <= sec_bus_idle_pin;
			idle_sync_reg <= idle_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire apb_access = psel && penable;
	wire apb_write = apb_access && pwrite;
	wire hit_ctrl = (paddr == BPS_OFF_PM_CTRL);
	wire hit_ext = (paddr == BPS_OFF_BRIDGE_EXT);
	wire hit_status = (paddr == BPS_OFF_BUS_STATUS);
	wire hit_table = (paddr >= BPS_OFF_PWR_TABLE) && (paddr <= BPS_OFF_PWR_TABLE_END) && (paddr[1:0] == 2'h0);
	wire hit_any = hit_ctrl || hit_ext || hit_status || hit_table;
	wire [3:0] table_index = 4'(paddr[7:2] - BPS_OFF_PWR_TABLE[7:2]);

	assign pready = 1'b1;
	assign pslverr = apb_access && !hit_any;

	// ----------------------------------------------------------------
	// strap capture after reset release
	// ----------------------------------------------------------------
	logic strap_done_reg, enable_reg, choice_reg;
	logic [3:0] load_idx_reg;
	wire loading = strap_load && (32'(load_idx_reg) < BPS_TABLE_DEPTH);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_reg <= 1'b0;
			enable_reg <= 1'b0;
			choice_reg <= 1'b0;
			load_idx_reg <= 4'h0;
		end else begin
			if (!strap_done_reg) begin
				strap_done_reg <= 1'b1;
				enable_reg <= strap_enable;
				choice_reg <= strap_choice;
			end
			if (loading) begin
				load_idx_reg <= load_idx_reg + 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic [3:0] sel_reg;
	bps_func_state_t func_reg;
	logic pwr_up_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= BPS_SEL_RESET;
			func_reg <= BPS_FUNC_FULL_POWER;
			pwr_up_reg <= 1'b1;
		end else if (apb_write && hit_ctrl) begin
			sel_reg <= pwdata[BPS_SEL_LSB +: 4];
			func_reg <= bps_func_state_t'(pwdata[BPS_PS_LSB +: 2]);
		end else if (apb_write && hit_ext) begin
			pwr_up_reg <= pwdata[BPS_PWR_UP_BIT];
		end
	end

	// ----------------------------------------------------------------
	// report table and window
	// ----------------------------------------------------------------
	wire tbl_wr = loading || (apb_write && hit_table);
	wire [3:0] tbl_wr_addr = loading ? load_idx_reg : table_index;
	bps_report_t tbl_wr_data;
	assign tbl_wr_data = loading ? strap_report : bps_report_t'(pwdata[9:0]);
	bps_report_t mem_rd;
	wire sel_common_ok = MULTI_FUNC && FUNC_ZERO;
	wire sel_valid = (sel_reg < BPS_SEL_COMMON) || ((sel_reg == BPS_SEL_COMMON) && sel_common_ok);
	wire [3:0] mem_rd_addr = sel_valid ? sel_reg : 4'hf;

	bps_report_mem #(
		.DEPTH(BPS_TABLE_DEPTH),
		.AW(4)
	) bps_report_mem_i (
		.clk(pclk),
		.wr_en(tbl_wr),
		.wr_addr(tbl_wr_addr),
		.wr_data(tbl_wr_data),
		.rd_addr(mem_rd_addr),
		.rd_data(mem_rd)
	);

	// entries 0-3 consumed, 4-7 dissipated, 8 common; each a state maximum
	bps_report_t report;
	assign report = sel_valid ? mem_rd : bps_report_t'('0);
	wire [1:0] scale_out = report.scale;

	// ----------------------------------------------------------------
	// bus state target
	// ----------------------------------------------------------------
	bps_bus_state_t target;
	wire hot_off = (func_reg == BPS_FUNC_HOT_OFF);
	assign target = !pwr_up_reg ? BPS_BUS_UNPOWERED :
		!enable_reg ? BPS_BUS_FULLY_ON :
		(func_reg == BPS_FUNC_LIGHT_SLEEP) ? BPS_BUS_POWERED_IDLE :
		(func_reg == BPS_FUNC_DEEP_SLEEP) ? BPS_BUS_CLOCK_STOPPED :
		(hot_off && choice_reg) ? BPS_BUS_CLOCK_STOPPED :
		hot_off ? BPS_BUS_UNPOWERED :
		BPS_BUS_FULLY_ON;

	// ----------------------------------------------------------------
	// secondary clock divider
	// ----------------------------------------------------------------
	logic [7:0] div_reg;
	logic sclk_reg;
	logic clk_run;
	wire div_tick = (div_reg == 8'(BPS_CLK_DIV / 2 - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 8'h00;
			sclk_reg <= 1'b0;
		end else if (div_tick) begin
			div_reg <= 8'h00;
			// only a rising edge is gated, so a stop lands on a full low phase
			sclk_reg <= sclk_reg ? 1'b0 : clk_run;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {S_ON, S_DRAIN, S_LOW, S_OFF, S_RESET} bps_seq_t;
	bps_seq_t seq_reg;
	bps_bus_state_t bus_reg;
	logic [31:0] cnt_reg;
	wire cnt_done = (cnt_reg == 32'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_reg <= S_ON;
			bus_reg <= BPS_BUS_FULLY_ON;
			cnt_reg <= 32'h0;
		end else begin
			if (!cnt_done) begin
				cnt_reg <= cnt_reg - 32'h1;
			end
			unique case (seq_reg)
				S_ON: begin
					if (target != BPS_BUS_FULLY_ON) begin
						seq_reg <= S_DRAIN;
						cnt_reg <= 32'(BPS_SETTLE_CYCLES);
					end
				end
				S_DRAIN: begin
					// bus must sit idle for the settle time before any change
					if (!idle_sync_reg) begin
						cnt_reg <= 32'(BPS_SETTLE_CYCLES);
					end else if (cnt_done) begin
						bus_reg <= target;
						seq_reg <= (target == BPS_BUS_UNPOWERED) ? S_OFF :
							(target == BPS_BUS_FULLY_ON) ? S_ON : S_LOW;
					end
				end
				S_LOW: begin
					if (target == BPS_BUS_UNPOWERED) begin
						bus_reg <= BPS_BUS_UNPOWERED;
						seq_reg <= S_OFF;
					end else begin
						bus_reg <= target;
						if (target == BPS_BUS_FULLY_ON) begin
							seq_reg <= S_ON;
						end
					end
				end
				S_OFF: begin
					if (target != BPS_BUS_UNPOWERED) begin
						seq_reg <= S_RESET;
						cnt_reg <= 32'(RESET_CYCLES);
					end
				end
				S_RESET: begin
					if (cnt_done) begin
						bus_reg <= BPS_BUS_FULLY_ON;
						seq_reg <= S_ON;
					end
				end
			endcase
		end
	end

	wire powered = (seq_reg != S_OFF);
	assign clk_run = (bus_reg == BPS_BUS_FULLY_ON) || (bus_reg == BPS_BUS_POWERED_IDLE) || (seq_reg == S_RESET);
	wire fully_on = (bus_reg == BPS_BUS_FULLY_ON) && (seq_reg == S_ON);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// grant block keeps arbitration parked, signals stay at valid levels
	assign sec_ctrl.sec_clk = sclk_reg;
	assign sec_ctrl.sec_power_on = powered;
	assign sec_ctrl.sec_reset_n = powered && (seq_reg != S_RESET);
	assign sec_ctrl.sec_grant_block = !fully_on;
	assign downstream_grant = downstream_req && fully_on;
	assign downstream_master_abort = downstream_req && !fully_on;
	assign bus_state = bus_reg;

	wire [31:0] ctrl_word = (32'(report.value) << BPS_DATA_LSB) | (32'(scale_out) << BPS_SCALE_LSB) |
		(32'(sel_reg) << BPS_SEL_LSB) | (32'(func_reg) << BPS_PS_LSB);
	wire [31:0] ext_word = (32'(enable_reg) << BPS_ENABLE_BIT) | (32'(choice_reg) << BPS_CHOICE_BIT) |
		(32'(pwr_up_reg) << BPS_PWR_UP_BIT);
	wire [31:0] status_word = {28'h0, 1'b0, fully_on, bus_reg};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= hit_ctrl ? ctrl_word : hit_ext ? ext_word : hit_status ? status_word : 32'h0;
		end
	end
endmodule
`default_nettype wire

/* File: bench/bps_power_monitor.sv */
// checker for the secondary bus control outputs
`timescale 1ns/1ps
`default_nettype none
module bps_power_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// secondary bus side
	input wire logic sec_bus_idle_pin,
	input wire logic downstream_req,
	input wire logic downstream_grant,
	input wire logic downstream_master_abort,
	input wire bps_pkg::bps_sec_ctrl_t sec_ctrl,
	input wire bps_pkg::bps_bus_state_t bus_state
);
	import bps_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic sec_clk_w;
	assign sec_clk_w = sec_ctrl.sec_clk;
	// grants may also be held back while draining, so only the safe direction is checked
	a_grant_when_on: assert property (downstream_grant |-> downstream_req && bus_state == BPS_BUS_FULLY_ON && !sec_ctrl.sec_grant_block)
		else $error("grant while bus not fully on");
	a_abort_when_low: assert property (downstream_req && bus_state != BPS_BUS_FULLY_ON |-> downstream_master_abort && !downstream_grant)
		else $error("master abort mismatch");
	a_stopped_clk_low: assert property (bus_state == BPS_BUS_CLOCK_STOPPED && !sec_clk_w |=> !sec_clk_w || bus_state != BPS_BUS_CLOCK_STOPPED)
		else $error("clock toggled while stopped");
	a_clk_full_high: assert property ($rose(sec_clk_w) |=> sec_clk_w [*8])
		else $error("short high phase");
	a_drain_before_exit: assert property (bus_state != BPS_BUS_FULLY_ON && $past(bus_state) == BPS_BUS_FULLY_ON |-> $past(sec_bus_idle_pin, 8))
		else $error("left fully on without idle bus");
	a_low_keeps_power: assert property (bus_state inside {BPS_BUS_POWERED_IDLE, BPS_BUS_CLOCK_STOPPED} |-> sec_ctrl.sec_power_on)
		else $error("supply lost in idle state");
	a_reset_on_return: assert property ($rose(sec_ctrl.sec_power_on) |-> !sec_ctrl.sec_reset_n)
		else $error("no bus reset on supply return");
	a_idle_clk_runs: assert property (bus_state == BPS_BUS_POWERED_IDLE |-> ##[1:12] ($changed(sec_clk_w) || bus_state != BPS_BUS_POWERED_IDLE))
		else $error("clock stalled in powered idle");
endmodule
bind bps_power_ctrl bps_power_monitor bps_power_monitor_i (.pclk(pclk), .presetn(presetn),
	.sec_bus_idle_pin(sec_bus_idle_pin), .downstream_req(downstream_req), .downstream_grant(downstream_grant),
	.downstream_master_abort(downstream_master_abort), .sec_ctrl(sec_ctrl), .bus_state(bus_state));
`default_nettype wire

/* File: bench/bps_sec_bus_model.sv */
// model of the functions on the secondary bus
`timescale 1ns/1ps
`default_nettype none
module bps_sec_bus_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// commands from the bench
	input wire logic quiet,
	input wire logic access,
	// secondary bus side
	output logic sec_bus_idle_pin,
	output logic downstream_req
);
	// outputs always at a defined level, busy after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_bus_idle_pin <= 1'b0;
			downstream_req <= 1'b0;
		end else begin
			sec_bus_idle_pin <= quiet;
			downstream_req <= access;
		end
	end
endmodule
`default_nettype wire

/* File: bench/bps_power_ctrl_tb.sv */
// testbench for the bus power sequencer
`timescale 1ns/1ps
`default_nettype none
module bps_power_ctrl_tb;
	import bps_pkg::*;
	localparam int RST_CYC = 20;
	// stand-in for the 50 ms settle after a clock restart, shortened to keep the run small
	localparam int RESUME_CYC = 100;
	logic strap_en, strap_ch, strap_ld;
	bps_report_t strap_rep;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, quiet, access, idle, req, grant, abort;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	bps_sec_ctrl_t sec_ctrl;
	bps_bus_state_t bus_state;
	int failures = 0;
	int total_checks = 0;
	bps_power_ctrl #(.RESET_CYCLES(RST_CYC)) bps_power_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .strap_enable(strap_en), .strap_choice(strap_ch), .strap_load(strap_ld),
		.strap_report(strap_rep),
		.sec_bus_idle_pin(idle), .downstream_req(req), .downstream_grant(grant),
		.downstream_master_abort(abort), .sec_ctrl(sec_ctrl), .bus_state(bus_state));
	bps_sec_bus_model bps_sec_bus_model_i (.pclk(pclk), .presetn(presetn), .quiet(quiet), .access(access),
		.sec_bus_idle_pin(idle), .downstream_req(req));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_state(input logic [1:0] s, input int lim);
		for (int i = 0; i < lim && bus_state !== s; i++) @(negedge pclk);
	endtask
	// mid-run reset with new straps, then one table entry per cycle from the strap bus
	task automatic pulse_reset(input logic en, input logic ch);
		@(posedge pclk);
		presetn <= 1'b0;
		strap_en <= en;
		strap_ch <= ch;
		strap_ld <= 1'b1;
		strap_rep <= {2'h0, 8'hc0};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 1; k < 10; k++) begin
			@(posedge pclk);
			strap_rep <= {2'(k), 8'(k + 8'hc0)};
		end
		strap_ld <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		logic [31:0] q;
		logic e;
		apb(1'b0, BPS_OFF_PM_CTRL, 32'h0, q, e);
		chk("sel and func", {q[12:9], q[1:0]}, {BPS_SEL_RESET, 2'h0});
		apb(1'b0, BPS_OFF_BRIDGE_EXT, 32'h0, q, e);
		chk("bridge ext", q[8:6], 3'b111);
		apb(1'b0, BPS_OFF_BUS_STATUS, 32'h0, q, e);
		chk("status", q[2:0], 3'b100);
		apb(1'b0, 8'h0c, 32'h0, q, e);
		chk("unmapped err", e, 1'b1);
	endtask
	task automatic t_report();
		logic [31:0] q;
		logic e;
		logic [13:0] x;
		for (int n = 0; n < 9; n++) apb(1'b1, BPS_OFF_PWR_TABLE + 8'(4 * n), {22'h0, 2'(n), 8'h10 + 8'(n)}, q, e);
		apb(1'b0, BPS_OFF_PWR_TABLE, 32'h0, q, e);
		chk("table read", q, 32'h0);
		for (int s = 0; s < 16; s++) begin
			apb(1'b1, BPS_OFF_PM_CTRL, 32'(s) << BPS_SEL_LSB, q, e);
			repeat (2) @(posedge pclk);
			apb(1'b0, BPS_OFF_PM_CTRL, 32'h0, q, e);
			x = (s < 9) ? {8'h10 + 8'(s), 2'(s), 4'(s)} : {10'h0, 4'(s)};
			chk("report", {q[23:16], q[14:9]}, x);
		end
	endtask
	task automatic t_states();
		logic [31:0] q;
		logic e;
		logic [1:0] x;
		for (int f = 1; f < 4; f++) begin
			x = (f == 1) ? 2'h1 : 2'h2;
			quiet <= 1'b0;
			apb(1'b1, BPS_OFF_PM_CTRL, 32'(f), q, e);
			repeat (40) @(negedge pclk);
			chk("drain hold", bus_state, BPS_BUS_FULLY_ON);
			quiet <= 1'b1;
			wait_state(x, 200);
			chk("bus state", bus_state, x);
			apb(1'b0, BPS_OFF_BUS_STATUS, 32'h0, q, e);
			chk("status low", q[2:0], {1'b0, x});
			access <= 1'b1;
			repeat (25) @(negedge pclk);
			chk("abort", {abort, grant}, 2'b10);
			chk("grant block", sec_ctrl.sec_grant_block, 1'b1);
			if (x == 2'h2) chk("clock low", sec_ctrl.sec_clk, 1'b0);
			access <= 1'b0;
			apb(1'b1, BPS_OFF_PM_CTRL, 32'h0, q, e);
			wait_state(BPS_BUS_FULLY_ON, 200);
			if (x == 2'h2) repeat (RESUME_CYC) @(negedge pclk);
			access <= 1'b1;
			repeat (3) @(negedge pclk);
			chk("grant", {abort, grant}, 2'b01);
			chk("grant open", sec_ctrl.sec_grant_block, 1'b0);
			access <= 1'b0;
		end
	endtask
	task automatic t_unpowered();
		logic [31:0] q;
		logic e;
		apb(1'b1, BPS_OFF_BRIDGE_EXT, 32'h0, q, e);
		wait_state(BPS_BUS_UNPOWERED, 200);
		chk("supply off", {bus_state, sec_ctrl.sec_power_on}, 3'b110);
		apb(1'b1, BPS_OFF_BRIDGE_EXT, 32'h1 << BPS_PWR_UP_BIT, q, e);
		for (int i = 0; i < 50 && sec_ctrl.sec_power_on !== 1'b1; i++) @(negedge pclk);
		chk("reset on return", sec_ctrl.sec_reset_n, 1'b0);
		wait_state(BPS_BUS_FULLY_ON, RST_CYC + 100);
		chk("bus back", {bus_state, sec_ctrl.sec_reset_n}, 3'b001);
	endtask
	task automatic t_straps();
		logic [31:0] q;
		logic e;
		pulse_reset(1'b1, 1'b0);
		apb(1'b0, BPS_OFF_BRIDGE_EXT, 32'h0, q, e);
		chk("strap ext", q[8:6], 3'b110);
		apb(1'b1, BPS_OFF_PM_CTRL, (32'h5 << BPS_SEL_LSB) | 32'h3, q, e);
		repeat (2) @(posedge pclk);
		apb(1'b0, BPS_OFF_PM_CTRL, 32'h0, q, e);
		chk("strap entry", {q[23:16], q[14:13]}, {8'hc5, 2'h1});
		wait_state(BPS_BUS_UNPOWERED, 200);
		chk("hot off unpowered", {bus_state, sec_ctrl.sec_power_on}, 3'b110);
		apb(1'b1, BPS_OFF_PM_CTRL, 32'h0, q, e);
		wait_state(BPS_BUS_FULLY_ON, RST_CYC + 100);
		chk("hot off return", bus_state, BPS_BUS_FULLY_ON);
		pulse_reset(1'b0, 1'b1);
		apb(1'b0, BPS_OFF_BRIDGE_EXT, 32'h0, q, e);
		chk("disabled ext", q[8:6], 3'b101);
		apb(1'b1, BPS_OFF_PM_CTRL, 32'h2, q, e);
		repeat (60) @(negedge pclk);
		apb(1'b0, BPS_OFF_BUS_STATUS, 32'h0, q, e);
		chk("disabled stays on", q[2:0], 3'b100);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, quiet, access} = '0;
		paddr = '0;
		pwdata = '0;
		{strap_en, strap_ch, strap_ld} = 3'b110;
		strap_rep = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_reset_values();
		t_report();
		t_states();
		t_unpowered();
		t_straps();
		report_and_stop();
	end
	// hang guard, more than twenty times the expected run
	initial begin
		#100000;
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
